// ---- rtl/dlpp_delay.sv ----
// Tapped flip-flop delay line selected by the delay code
`timescale 1ns/100ps
module dlpp_delay #(
    parameter int CODE_W   = 8,
    parameter int BASE_CYC = 1,
    parameter int STEP_CYC = 1
) (
    input  wire logic              i_clock,
    input  wire logic              i_reset,
    input  wire logic              i_level,
    input  wire logic [CODE_W-1:0] i_code,
    output logic                   o_level
);

    localparam int DEPTH = BASE_CYC + ((1 << CODE_W) - 1) * STEP_CYC;
    localparam int TAP_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [DEPTH-1:0] line_q;
    logic [TAP_W-1:0] tap;
    logic             out_q;

    initial begin
        if (CODE_W < 1 || BASE_CYC < 1 || STEP_CYC < 1)
            $error("dlpp_delay: widths and cycle counts must be at least 1");
    end

    // Tap grows linearly with the code, code zero at the step-zero tap
    always_comb begin
        tap = TAP_W'(BASE_CYC - 1 + int'(i_code) * STEP_CYC);
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            line_q <= '0;
        end else begin
            line_q <= {line_q[DEPTH-2:0], i_level};
        end
    end

    // Level passes unchanged, no inversion
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            out_q <= 1'b0;
        end else begin
            out_q <= line_q[tap];
        end
    end

    assign o_level = out_q;

    // Checked against the input itself at the step-zero tap, not against the tap mux
    AST_NO_INVERT: assert property (@(posedge i_clock) disable iff (i_reset)
        i_code == '0 |=> o_level == $past(i_level, BASE_CYC + 1))
        else $error("Step-zero output differs from the input level");

endmodule

// ---- rtl/dlpp_pkg.sv ----
// Shared constants and types of the delay line programming port
package dlpp_pkg;

    // ************************************************************
    // Code layout
    // ************************************************************
    localparam int         CODE_W   = 8;
    localparam int         CODE_MSB = CODE_W - 1;
    localparam logic [7:0] CODE_RST = 8'h00;
    localparam logic       MODE_PAR = 1'b1;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_PERIOD_PS = 100000;
    localparam int SYNC_STAGES   = 2;
    // Step-zero delay and per-step increment, in picoseconds
    localparam int BASE_DELAY_PS = 10000;
    localparam int STEP_DELAY_PS = 150;
    // Settling time after a code change, in microseconds
    localparam int SETTLE_US     = 50;

    // Sub-cycle figures still cost one whole cycle
    function automatic int ceil_cyc(input int time_ps);
        int n;
        n = (time_ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (n < 1) ? 1 : n;
    endfunction

    localparam int BASE_CYC   = ceil_cyc(BASE_DELAY_PS);
    localparam int STEP_CYC   = ceil_cyc(STEP_DELAY_PS);
    localparam int SETTLE_CYC = ceil_cyc(SETTLE_US * 1000000);
    localparam int SETTLE_W   = $clog2(SETTLE_CYC + 1);

    // ************************************************************
    // Port state
    // ************************************************************
    typedef enum logic [2:0] {
        PORT_IDLE = 3'b001,
        PORT_SER  = 3'b010,
        PORT_PAR  = 3'b100
    } dlpp_port_t;

endpackage

// ---- rtl/dlpp_sync.sv ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module dlpp_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clock,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;

    initial begin
        if (WIDTH < 1) $error("dlpp_sync: WIDTH must be at least 1");
    end

    // First stage feeds the second and nothing else
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            stage1_q <= '0;
            stage2_q <= '0;
        end else begin
            stage1_q <= i_async;
            stage2_q <= stage1_q;
        end
    end

    assign o_sync = stage2_q;

endmodule

// ---- rtl/dlpp_top.sv ----
// Programming port and delay path of the 8-bit programmable delay line
// Behaviour
// - Mode pin high takes the delay code from the parallel program bus.
// - Mode pin low takes the delay code from an 8-bit serial shift.
// - Load gate high passes the bus through; falling gate latches it.
// - Serial data sampled on each rising serial clock edge, MSB first.
// - Gate high for serial load or read; old code stays active meanwhile.
// - Gate falling ends the serial transfer and activates the shifted code.
// - Each new bit pushes the prior contents out the serial output, MSB first.
// - Gate raised with serial clock low presents bit 7 on the serial output.
// - First rising edge of a read rewrites bit 7 and presents bit 6.
// - Code restored unchanged at gate fall keeps delay and starts no settling.
// - 256 equal steps selected by the code; output not inverted.
// - Delay is step-zero delay plus code times step; bus bit 7 is MSB.
// - Serial output shares the terminal of program bus bit 0.
`timescale 1ns/100ps
module dlpp_top #(
    parameter int CODE_W     = dlpp_pkg::CODE_W,
    parameter int BASE_CYC   = dlpp_pkg::BASE_CYC,
    parameter int STEP_CYC   = dlpp_pkg::STEP_CYC,
    parameter int SETTLE_CYC = dlpp_pkg::SETTLE_CYC
) (
    input  wire logic              i_clock,
    input  wire logic              i_reset,
    input  wire logic              i_delay_in,
    input  wire logic              i_mode_sel,
    input  wire logic              i_load_gate,
    input  wire logic              i_serial_clk,
    input  wire logic              i_serial_data,
    input  wire logic [CODE_W-1:0] i_prog_bus,
    output logic                   o_serial_out,
    output logic                   o_serial_oe_n,
    output logic                   o_delay_out,
    output logic [CODE_W-1:0]      o_active_code,
    output logic                   o_settled
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    initial begin
        if (CODE_W != dlpp_pkg::CODE_W)
            $error("dlpp_top: serial framing is fixed at the package code width");
        if (SETTLE_CYC < 4 || SETTLE_CYC >= (1 << dlpp_pkg::SETTLE_W))
            $error("dlpp_top: SETTLE_CYC out of range");
    end

    localparam int SETTLE_BND = SETTLE_CYC + 1;
    localparam logic [dlpp_pkg::SETTLE_W-1:0] SETTLE_LOAD = dlpp_pkg::SETTLE_W'(SETTLE_CYC);
    localparam logic [dlpp_pkg::SETTLE_W-1:0] SETTLE_ZERO = '0;
    localparam logic [dlpp_pkg::SETTLE_W-1:0] SETTLE_ONE  = dlpp_pkg::SETTLE_W'(1);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    localparam int PIN_W = CODE_W + 5;

    logic [PIN_W-1:0]  pins_s;
    logic              delay_in_s;
    logic              mode_s;
    logic              gate_s;
    logic              sclk_s;
    logic              sdata_s;
    logic [CODE_W-1:0] bus_s;

    // Every pin crosses two flops; the serial clock is just another level
    dlpp_sync #(
        .WIDTH (PIN_W)
    ) u_sync (
        .i_clock (i_clock),
        .i_reset (i_reset),
        .i_async ({i_delay_in, i_mode_sel, i_load_gate, i_serial_clk,
                   i_serial_data, i_prog_bus}),
        .o_sync  (pins_s)
    );

    assign {delay_in_s, mode_s, gate_s, sclk_s, sdata_s, bus_s} = pins_s;

    // ************************************************************
    // Edge detection
    // ************************************************************
    logic sclk_d1_q;
    logic gate_d1_q;
    logic sclk_rise;
    logic gate_fall;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            sclk_d1_q <= 1'b0;
            gate_d1_q <= 1'b0;
        end else begin
            sclk_d1_q <= sclk_s;
            gate_d1_q <= gate_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d1_q;
    assign gate_fall = gate_d1_q & ~gate_s;

    // ************************************************************
    // Port state
    // ************************************************************
    dlpp_pkg::dlpp_port_t state_q;
    dlpp_pkg::dlpp_port_t state_d;

    function automatic logic is_serial(input logic mode);
        return mode != dlpp_pkg::MODE_PAR;
    endfunction

    always_comb begin
        state_d = dlpp_pkg::PORT_IDLE;
        if (gate_s && !is_serial(mode_s)) begin
            state_d = dlpp_pkg::PORT_PAR;
        end else if (gate_s && is_serial(mode_s)) begin
            state_d = dlpp_pkg::PORT_SER;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state_q <= dlpp_pkg::PORT_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ************************************************************
    // Serial input register
    // ************************************************************
    logic [CODE_W-1:0] shift_q;
    logic              shift_en;

    // Shifting only while the gate is open in serial mode
    assign shift_en = sclk_rise && gate_s && is_serial(mode_s);

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            shift_q <= dlpp_pkg::CODE_RST;
        end else if (shift_en) begin
            // New bit enters at the bottom, MSB leaves first
            shift_q <= {shift_q[CODE_W-2:0], sdata_s};
        end
    end

    // ************************************************************
    // Active delay code
    // ************************************************************
    logic [CODE_W-1:0] active_q;
    logic              commit;
    logic              code_change;

    // Commit only on a gate fall seen in serial mode; a mode change
    // mid-transfer drops the shifted value
    assign commit = (state_q == dlpp_pkg::PORT_SER) && gate_fall && is_serial(mode_s);

    assign code_change = ((state_q == dlpp_pkg::PORT_PAR || state_d == dlpp_pkg::PORT_PAR)
                          && gate_s && bus_s != active_q)
                       || (commit && shift_q != active_q);

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            active_q <= dlpp_pkg::CODE_RST;
        end else if (gate_s && !is_serial(mode_s)) begin
            // Transparent while the gate is high, held when it falls
            active_q <= bus_s;
        end else if (commit) begin
            active_q <= shift_q;
        end
    end

    // ************************************************************
    // Settling tracker
    // ************************************************************
    logic [dlpp_pkg::SETTLE_W-1:0] settle_cnt_q;
    logic                          settled_q;

    // Restored code leaves the counter alone, so no new settling
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            settle_cnt_q <= SETTLE_ZERO;
        end else if (code_change) begin
            settle_cnt_q <= SETTLE_LOAD;
        end else if (settle_cnt_q != SETTLE_ZERO) begin
            settle_cnt_q <= settle_cnt_q - SETTLE_ONE;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            settled_q <= 1'b1;
        end else begin
            settled_q <= !code_change && (settle_cnt_q <= SETTLE_ONE);
        end
    end

    // ************************************************************
    // Shared serial output terminal
    // ************************************************************
    logic sout_q;
    logic sout_oe_n_q;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            sout_q <= 1'b0;
        end else begin
            sout_q <= shift_q[dlpp_pkg::CODE_MSB];
        end
    end

    // Bus bit 0 is an input in parallel mode, so drive only in serial
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            sout_oe_n_q <= 1'b1;
        end else begin
            sout_oe_n_q <= !(gate_s && is_serial(mode_s));
        end
    end

    // ************************************************************
    // Delay path
    // ************************************************************
    dlpp_delay #(
        .CODE_W   (CODE_W),
        .BASE_CYC (BASE_CYC),
        .STEP_CYC (STEP_CYC)
    ) u_delay (
        .i_clock (i_clock),
        .i_reset (i_reset),
        .i_level (delay_in_s),
        .i_code  (active_q),
        .o_level (o_delay_out)
    );

    assign o_serial_out  = sout_q;
    assign o_serial_oe_n = sout_oe_n_q;
    assign o_active_code = active_q;
    assign o_settled     = settled_q;

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence ser_open_s;
        gate_s && is_serial(mode_s);
    endsequence

    sequence ser_restore_s;
        commit && shift_q == active_q && settle_cnt_q == SETTLE_ZERO;
    endsequence

    AST_PAR_TRACK: assert property (@(posedge i_clock) disable iff (i_reset)
        gate_s && !is_serial(mode_s) |=> active_q == $past(bus_s))
        else $error("Parallel code not taken from bus");

    AST_PAR_LATCH: assert property (@(posedge i_clock) disable iff (i_reset)
        !gate_s && !is_serial(mode_s) && !commit |=> $stable(active_q))
        else $error("Latched parallel code moved with gate low");

    AST_SER_SHIFT: assert property (@(posedge i_clock) disable iff (i_reset)
        shift_en |=> shift_q == {$past(shift_q[CODE_W-2:0]), $past(sdata_s)})
        else $error("Serial bit not shifted in at the bottom");

    AST_SER_HOLD: assert property (@(posedge i_clock) disable iff (i_reset)
        ser_open_s |=> $stable(active_q))
        else $error("Active code changed during serial transfer");

    AST_SER_COMMIT: assert property (@(posedge i_clock) disable iff (i_reset)
        $past(gate_s) && !gate_s && is_serial(mode_s) && state_q == dlpp_pkg::PORT_SER
        |=> active_q == $past(shift_q))
        else $error("Shift register not activated at gate fall");

    AST_SOUT_MSB: assert property (@(posedge i_clock) disable iff (i_reset)
        ser_open_s ##1 !o_serial_oe_n |-> o_serial_out == $past(shift_q[dlpp_pkg::CODE_MSB]))
        else $error("Serial output is not the register MSB");

    // Bit 7 must stand before any shift, or a read loses the MSB
    AST_READ_START: assert property (@(posedge i_clock) disable iff (i_reset)
        $rose(gate_s) && is_serial(mode_s) && !sclk_s
        |=> !o_serial_oe_n && o_serial_out == $past(shift_q[dlpp_pkg::CODE_MSB]))
        else $error("Bit 7 not shown on the serial output when a read opens");

    AST_READ_BIT6: assert property (@(posedge i_clock) disable iff (i_reset)
        shift_en ##1 ser_open_s |=> o_serial_out == $past(shift_q[dlpp_pkg::CODE_MSB - 1], 2))
        else $error("Bit 6 not presented after first serial edge");

    AST_NO_RESETTLE: assert property (@(posedge i_clock) disable iff (i_reset)
        ser_restore_s ##1 !code_change |=> o_settled && $stable(active_q))
        else $error("Restored code started a new settling");

    AST_SETTLE_END: assert property (@(posedge i_clock) disable iff (i_reset)
        code_change ##1 (!code_change)[*3] |-> !o_settled ##[1:SETTLE_BND] o_settled)
        else $error("Settling window wrong after code change");

    AST_OE_MODE: assert property (@(posedge i_clock) disable iff (i_reset)
        o_serial_oe_n == !$past(gate_s && is_serial(mode_s)))
        else $error("Serial output driven outside a serial transfer");

    AST_OE_PAR_OFF: assert property (@(posedge i_clock) disable iff (i_reset)
        !is_serial(mode_s) && !is_serial($past(mode_s)) |-> o_serial_oe_n)
        else $error("Shared terminal driven in parallel mode");

endmodule

// ---- verif/dlpp_host_model.sv ----
// Host controller model that drives the programming pins
`timescale 1ns/100ps
module dlpp_host_model (
    input  wire logic  i_clock,
    output logic       o_mode_sel,
    output logic       o_load_gate,
    output logic       o_serial_clk,
    output logic       o_serial_data,
    output logic       o_data_drive,
    output logic [7:0] o_prog_bus
);
    // ****************************************
    // Idle levels
    // ****************************************
    initial begin
        o_mode_sel    = 1'b1;
        o_load_gate   = 1'b1;
        o_serial_clk  = 1'b0;
        o_serial_data = 1'b0;
        o_data_drive  = 1'b1;
        o_prog_bus    = 8'h00;
    end

    // ****************************************
    // Pin sequencing
    // ****************************************
    // Pins move one step after the edge, never on it
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    // Gate held high so the bus acts directly
    task automatic par_drive(input logic [7:0] code);
        o_mode_sel  = 1'b1;
        o_load_gate = 1'b1;
        o_prog_bus  = code;
        wait_cyc(5);
    endtask

    // Bus stays stable past the gate fall, then moves to show the latch
    task automatic par_latch();
        o_load_gate = 1'b0;
        wait_cyc(4);
        o_prog_bus = ~o_prog_bus;
        wait_cyc(5);
    endtask

    // Gate rises only while the serial clock rests low
    task automatic ser_open();
        o_load_gate  = 1'b0;
        o_mode_sel   = 1'b0;
        o_serial_clk = 1'b0;
        wait_cyc(4);
        o_load_gate = 1'b1;
        wait_cyc(4);
    endtask

    // One 800 ns serial clock period: 3 cycles low, 5 high
    task automatic ser_bit(input logic b, input logic drive);
        o_data_drive  = drive;
        o_serial_data = b;
        wait_cyc(3);
        o_serial_clk = 1'b1;
        wait_cyc(5);
        o_serial_clk = 1'b0;
    endtask

    task automatic ser_close();
        wait_cyc(2);
        o_load_gate  = 1'b0;
        o_data_drive = 1'b1;
        wait_cyc(5);
    endtask
endmodule

// ---- verif/tb_dlpp_top.sv ----
// Self-checking bench of the delay line programming port
`timescale 1ns/100ps
module tb_dlpp_top;
    // ****************************************
    // Signals
    // ****************************************
    typedef struct {
        string      name;
        logic [8:0] exp;
    } dlpp_note_t;

    logic       clock;
    logic       reset;
    logic       delay_in;
    logic       mode_sel;
    logic       load_gate;
    logic       serial_clk;
    logic       host_data;
    logic       host_drive;
    logic       data_prev;
    logic       serial_data;
    logic [7:0] host_bus;
    logic [7:0] prog_bus;
    logic       serial_out;
    logic       serial_oe_n;
    logic       delay_out;
    logic [7:0] active_code;
    logic       settled;
    logic [8:0] meas_n;
    logic [7:0] code_p;
    logic [7:0] code_a;
    logic [7:0] code_b;
    logic [7:0] dcodes[3];
    dlpp_note_t notes[$];
    dlpp_note_t note;
    logic [8:0] seen;
    int         miscompares;
    int         samples_checked;
    event       observe;

    // ****************************************
    // Clock, wires and instances
    // ****************************************
    initial clock = 1'b0;
    always #50 clock = ~clock;

    // A released data line with nothing driving it wanders every cycle
    initial data_prev = 1'b0;
    always @(posedge clock) data_prev <= serial_data;
    assign serial_data = host_drive ? host_data : (!serial_oe_n ? serial_out : ~data_prev);
    assign prog_bus    = {host_bus[7:1], serial_oe_n ? host_bus[0] : serial_out};

    dlpp_host_model u_host (
        .i_clock       (clock),
        .o_mode_sel    (mode_sel),
        .o_load_gate   (load_gate),
        .o_serial_clk  (serial_clk),
        .o_serial_data (host_data),
        .o_data_drive  (host_drive),
        .o_prog_bus    (host_bus)
    );

    // Short settling keeps the run brief
    dlpp_top #(.SETTLE_CYC(8)) u_dut (
        .i_clock       (clock),
        .i_reset       (reset),
        .i_delay_in    (delay_in),
        .i_mode_sel    (mode_sel),
        .i_load_gate   (load_gate),
        .i_serial_clk  (serial_clk),
        .i_serial_data (serial_data),
        .i_prog_bus    (prog_bus),
        .o_serial_out  (serial_out),
        .o_serial_oe_n (serial_oe_n),
        .o_delay_out   (delay_out),
        .o_active_code (active_code),
        .o_settled     (settled)
    );

    // ****************************************
    // Scoreboard
    // ****************************************
    task automatic expect_now(input string nm, input logic [8:0] e);
        notes.push_back('{nm, e});
        -> observe;
    endtask

    always @(observe) begin
        while (notes.size() > 0) begin
            note = notes.pop_front();
            case (note.name)
                "active_code": seen = {1'b0, active_code};
                "serial_out":  seen = {8'h00, serial_out};
                "serial_oe_n": seen = {8'h00, serial_oe_n};
                "settled":     seen = {8'h00, settled};
                "delay_out":   seen = {8'h00, delay_out};
                default:       seen = meas_n;
            endcase
            samples_checked++;
            if (seen !== note.exp) begin
                miscompares++;
                $display("mismatch %s expected %0h seen %0h", note.name, note.exp, seen);
            end
        end
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wait_settled();
        for (int n = 0; n < 40 && settled !== 1'b1; n++) begin
            u_host.wait_cyc(1);
        end
    endtask

    // Long hold first so every tap carries the same level
    task automatic measure(input logic [7:0] c);
        int n;
        int e;
        u_host.par_drive(c);
        u_host.wait_cyc(300);
        delay_in = ~delay_in;
        n = 0;
        while (delay_out !== delay_in && n < 400) begin
            u_host.wait_cyc(1);
            n++;
        end
        meas_n = 9'(n);
        // Synchroniser stages and the output register add to the tap depth
        e = int'(c) * dlpp_pkg::STEP_CYC + dlpp_pkg::BASE_CYC + dlpp_pkg::SYNC_STAGES + 1;
        expect_now("delay_n", 9'(e));
        expect_now("delay_out", {8'h00, delay_in});
    endtask

    // ****************************************
    // Watchdog
    // ****************************************
    initial begin
        repeat (6000) @(posedge clock);
        miscompares++;
        $display("watchdog expired");
        complete_run();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        delay_in        = 1'b0;
        reset           = 1'b1;
        meas_n          = 9'h000;
        miscompares     = 0;
        samples_checked = 0;
        repeat (16) @(posedge clock);
        #1;
        reset = 1'b0;
        void'($urandom(32'h120d));
        u_host.wait_cyc(4);

        // Bit 0 forced high to exercise the shared terminal
        code_p = 8'($urandom()) | 8'h01;
        u_host.par_drive(code_p);
        expect_now("active_code", {1'b0, code_p});
        expect_now("serial_oe_n", 9'h001);
        u_host.par_latch();
        expect_now("active_code", {1'b0, code_p});
        $display("parallel test done");

        // Two chained groups: the second is kept, the first leaves by the output
        code_a = 8'($urandom());
        code_b = 8'($urandom());
        if (code_b == code_p) begin
            code_b = code_b ^ 8'h01;
        end
        u_host.ser_open();
        for (int i = 15; i >= 0; i--) begin
            if (i < 8) begin
                expect_now("serial_out", {8'h00, code_a[i]});
            end
            u_host.ser_bit(i > 7 ? code_a[i-8] : code_b[i], 1'b1);
        end
        expect_now("active_code", {1'b0, code_p});
        u_host.ser_close();
        expect_now("active_code", {1'b0, code_b});
        expect_now("settled", 9'h000);
        expect_now("serial_oe_n", 9'h001);
        $display("serial chain test done");

        wait_settled();
        u_host.ser_open();
        expect_now("serial_oe_n", 9'h000);
        expect_now("serial_out", {8'h00, code_b[7]});
        for (int i = 6; i >= -1; i--) begin
            u_host.ser_bit(1'b0, 1'b0);
            expect_now("serial_out", {8'h00, code_b[i < 0 ? 7 : i]});
        end
        u_host.ser_close();
        expect_now("active_code", {1'b0, code_b});
        expect_now("settled", 9'h001);
        $display("readback test done");

        dcodes[0] = 8'h00;
        dcodes[1] = 8'hFF;
        dcodes[2] = 8'($urandom());
        foreach (dcodes[k]) begin
            measure(dcodes[k]);
        end
        $display("delay test done");
        #1;
        complete_run();
    end
endmodule
